/* File: design/ucs_pkg.sv */
// package: register map, codes and counts of the uart clock/command block
// Overview of operation
// R1: rx clock source chosen by bits 7-4
// R2: tx clock source chosen by bits 3-0
// R3: tx and rx may use different sources
// R4: software writes 0xDD for bus clock both
// R5: software avoids conflicting commands in one write
// R6: misc field bits 6-4, 000 does nothing
// R7: misc 001 resets mode register pointer
// R8: misc 010 resets receiver and its flags
// R9: software prefers receiver reset when reconfiguring
// R10: misc 011 resets transmitter and its flags
// R11: misc 100 clears all error flags
// R12: misc 101 clears delta break flag
// R13: misc 110 starts break after current character
// R14: break needs tx enabled, ignores cts
// R15: misc 111 ends break, then buffered characters
// R16: tx field bits 3-2, 00 keeps state
// R17: tx 01 enables, sets empty and ready
// R18: tx 10 disables after current character
// R19: software never writes tx code 11
// R20: rx 01 enables and hunts start bit; the code ignores it while multidrop_mode is high
// R21: rx 10 disables, loopback/multidrop keep running
// R22: each command acts once as pulse
package ucs_pkg;
    // byte offsets on the bus
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CLKSEL = 8'h04;
    localparam logic [7:0] OFF_CMD = 8'h08;
    localparam logic [7:0] OFF_TXDATA = 8'h0C;
    localparam logic [7:0] OFF_RXPOP = 8'h10;
    // field positions
    localparam int RXSEL_LSB = 4;
    localparam int TXSEL_LSB = 0;
    localparam int MISC_LSB = 4;
    localparam int TC_LSB = 2;
    localparam int RC_LSB = 0;
    // clock source codes
    localparam logic [3:0] SEL_PRESC = 4'hD;
    localparam logic [3:0] SEL_EXT16 = 4'hE;
    localparam logic [3:0] SEL_EXT1 = 4'hF;
    // clock select after reset: no source
    localparam logic [7:0] CLKSEL_RST = 8'h00;
    // misc command codes
    localparam logic [2:0] MISC_NONE = 3'h0;
    localparam logic [2:0] MISC_PTR = 3'h1;
    localparam logic [2:0] MISC_RSTRX = 3'h2;
    localparam logic [2:0] MISC_RSTTX = 3'h3;
    localparam logic [2:0] MISC_RSTERR = 3'h4;
    localparam logic [2:0] MISC_RSTBRK = 3'h5;
    localparam logic [2:0] MISC_STARTBRK = 3'h6;
    localparam logic [2:0] MISC_STOPBRK = 3'h7;
    // tx and rx command codes
    localparam logic [1:0] TC_EN = 2'h1;
    localparam logic [1:0] TC_DIS = 2'h2;
    localparam logic [1:0] RC_EN = 2'h1;
    localparam logic [1:0] RC_DIS = 2'h2;
    // counts in cycles or ticks
    localparam logic [7:0] PRESC_LAST = 8'h1F;
    localparam logic [3:0] DIV16_LAST = 4'hF;
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;
    localparam logic [1:0] FIFO_FULL = 2'h3;
    // transmitter states, gray along the frame
    typedef enum logic [2:0] {
        TX_IDLE = 3'h0,
        TX_START = 3'h1,
        TX_DATA = 3'h3,
        TX_STOP = 3'h2,
        TX_BRK = 3'h6
    } ucs_tx_state_t;
    // true for a code that names a clock source
    function automatic logic ucs_sel_ok(input logic [3:0] s);
        return (s == SEL_PRESC) || (s == SEL_EXT16) || (s == SEL_EXT1);
    endfunction : ucs_sel_ok
endpackage : ucs_pkg

/* File: design/ucs_clk_src.sv */
// clock source selector making one bit-time tick
`timescale 1ns/1ps
module ucs_clk_src (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [3:0] sel,
    input wire logic presc_tick,
    input wire logic ext_rise,
    output logic bit_tick
);
    import ucs_pkg::*;
    logic [3:0] ext_cnt_q; // external edge divider
    logic [3:0] os_cnt_q; // source ticks per bit
    logic bit_tick_q; // bit time strobe
    wire ext_div = ext_rise & (ext_cnt_q == DIV16_LAST);
    // source mux, unknown codes give no clock
    wire src_tick = (sel == SEL_PRESC) ? presc_tick :
                    (sel == SEL_EXT16) ? ext_div :
                    (sel == SEL_EXT1) ? ext_rise : 1'b0; // see R1 see R2
    wire [3:0] ext_cnt_d = ext_rise ? ext_cnt_q + 4'h1 : ext_cnt_q;
    wire [3:0] os_cnt_d = src_tick ? os_cnt_q + 4'h1 : os_cnt_q;
    // counters and strobe
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_cnt_q <= 4'h0;
            os_cnt_q <= 4'h0;
            bit_tick_q <= 1'b0;
        end else begin
            ext_cnt_q <= ext_cnt_d;
            os_cnt_q <= os_cnt_d;
            bit_tick_q <= src_tick & (os_cnt_q == DIV16_LAST);
        end
    end
    assign bit_tick = bit_tick_q;
endmodule : ucs_clk_src

/* File: design/ucs_top.sv */
// uart channel clock select and command decode with ahb-lite slave
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module ucs_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ext_timer_clock_in,
    input wire logic clear_to_send_in_n,
    input wire logic multidrop_mode,
    input wire logic loopback_mode,
    input wire logic rx_char_in,
    input wire logic rx_break_in,
    input wire logic rx_frame_err_in,
    input wire logic rx_parity_err_in,
    input wire logic rx_break_change_in,
    output logic serial_tx_out,
    output logic rx_enable,
    output logic rx_hunt_start,
    output logic rx_fifo_reset,
    output logic mode_ptr_reset,
    output logic rx_bit_tick
);
    import ucs_pkg::*;

    // word address match
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction : hit

    // bus phase tracking
    logic wr_pend_q; // write data phase due
    logic [7:0] wr_addr_q; // write address held
    logic [31:0] rdata_q; // read data
    logic ready_q; // always ready
    wire ap_valid = hsel & htrans[1] & hready;
    wire ap_rd = ap_valid & ~hwrite;
    wire [7:0] ap_addr = haddr[7:0];

    // register state
    logic [7:0] csr_q; // clock select
    wire [3:0] rx_sel_q = csr_q[RXSEL_LSB +: 4];
    wire [3:0] tx_sel_q = csr_q[TXSEL_LSB +: 4];
    logic tx_en_q; // transmitter enabled
    logic tx_rdy_q; // holding empty
    logic tx_emp_q; // nothing left to send
    logic rx_en_q; // receiver enabled by command
    logic [1:0] fifo_cnt_q; // receive fifo fill
    logic rb_q; // received break
    logic fe_q; // framing error
    logic pe_q; // parity error
    logic oe_q; // overrun error
    logic db_q; // delta break
    logic rx_act_q; // receiver running
    logic hunt_q; // start-bit hunt pulse
    logic fifo_rst_q; // fifo pointer reset pulse
    logic mptr_q; // mode pointer reset pulse

    // write decode
    wire wr_csr = wr_pend_q & hit(wr_addr_q, OFF_CLKSEL);
    wire cmd_wr = wr_pend_q & hit(wr_addr_q, OFF_CMD);
    wire tx_wr = wr_pend_q & hit(wr_addr_q, OFF_TXDATA);
    wire [2:0] misc = hwdata[MISC_LSB +: 3];
    wire [1:0] tc = hwdata[TC_LSB +: 2];
    wire [1:0] rc = hwdata[RC_LSB +: 2];

    // one pulse per command, no stored command
    wire c_mptr = cmd_wr & (misc == MISC_PTR); // see R22
    wire c_rst_rx = cmd_wr & (misc == MISC_RSTRX);
    wire c_rst_tx = cmd_wr & (misc == MISC_RSTTX);
    wire c_rst_err = cmd_wr & (misc == MISC_RSTERR);
    wire c_rst_brk = cmd_wr & (misc == MISC_RSTBRK);
    wire c_start_brk = cmd_wr & (misc == MISC_STARTBRK);
    wire c_stop_brk = cmd_wr & (misc == MISC_STOPBRK);
    wire c_tx_en = cmd_wr & (tc == TC_EN);
    wire c_tx_dis = cmd_wr & (tc == TC_DIS);
    wire c_rx_en = cmd_wr & (rc == RC_EN);
    wire c_rx_dis = cmd_wr & (rc == RC_DIS);

    // bus slave: zero wait states, okay only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            ready_q <= 1'b1;
        end else begin
            wr_pend_q <= ap_valid & hwrite;
            wr_addr_q <= ap_addr;
            ready_q <= 1'b1;
        end
    end

    // clock select register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            csr_q <= CLKSEL_RST;
        end else if (wr_csr) begin
            csr_q <= hwdata[7:0]; // see R1 see R2
        end
    end

    // prescaler and external edge
    logic [7:0] presc_q; // bus clock prescaler
    logic ext_q; // last external level
    wire presc_tick = (presc_q == PRESC_LAST);
    wire ext_rise = ext_timer_clock_in & ~ext_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_q <= 8'h00;
            ext_q <= 1'b0;
        end else begin
            presc_q <= presc_tick ? 8'h00 : presc_q + 8'h01;
            ext_q <= ext_timer_clock_in;
        end
    end

    // independent sources for each direction
    logic tx_tick; // transmit bit time
    ucs_clk_src u_tx_src (
        .hclk(hclk),
        .hresetn(hresetn),
        .sel(tx_sel_q),
        .presc_tick(presc_tick),
        .ext_rise(ext_rise),
        .bit_tick(tx_tick)
    ); // see R3
    ucs_clk_src u_rx_src (
        .hclk(hclk),
        .hresetn(hresetn),
        .sel(rx_sel_q),
        .presc_tick(presc_tick),
        .ext_rise(ext_rise),
        .bit_tick(rx_bit_tick)
    ); // see R3

    // transmitter state
    ucs_tx_state_t st_q, st_d;
    logic [7:0] sh_q, sh_d; // shift register
    logic [7:0] hold_q, hold_d; // holding register
    logic [2:0] bit_q, bit_d; // data bit index
    logic txo_q, txo_d; // line level
    logic bp_q, bp_d; // break pending
    logic be_q, be_d; // break end requested
    logic ten_d, trdy_d, temp_d;
    wire tx_take = tx_wr & tx_en_q & tx_rdy_q;

    // transmitter next state and command effects
    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        hold_d = hold_q;
        bit_d = bit_q;
        txo_d = txo_q;
        bp_d = bp_q;
        be_d = be_q;
        ten_d = tx_en_q;
        trdy_d = tx_rdy_q;
        temp_d = tx_emp_q;
        // new character into holding register
        if (tx_take) begin
            hold_d = hwdata[7:0];
            trdy_d = 1'b0;
            temp_d = 1'b0;
        end
        unique case (st_q)
            TX_IDLE: begin
                if (tx_tick && bp_q) begin
                    st_d = TX_BRK; // see R13
                    txo_d = 1'b0;
                    bp_d = 1'b0;
                end else if (tx_tick && tx_en_q && !tx_rdy_q && !clear_to_send_in_n) begin
                    sh_d = hold_q;
                    trdy_d = 1'b1;
                    st_d = TX_START;
                    txo_d = 1'b0;
                end
            end
            TX_START: begin
                if (tx_tick) begin
                    st_d = TX_DATA;
                    txo_d = sh_q[0];
                    bit_d = 3'h0;
                end
            end
            TX_DATA: begin
                if (tx_tick && bit_q == LAST_DATA_BIT) begin
                    st_d = TX_STOP;
                    txo_d = 1'b1;
                end else if (tx_tick) begin
                    sh_d = {1'b0, sh_q[7:1]};
                    txo_d = sh_q[1];
                    bit_d = bit_q + 3'h1;
                end
            end
            TX_STOP: begin
                if (tx_tick) begin
                    st_d = TX_IDLE;
                    temp_d = tx_en_q & trdy_d;
                end
            end
            TX_BRK: begin
                // line held low until the end request meets a tick
                if (tx_tick && be_q) begin
                    st_d = TX_IDLE; // see R15
                    txo_d = 1'b1;
                    be_d = 1'b0;
                end
            end
            default: begin
                st_d = TX_IDLE;
                txo_d = 1'b1;
            end
        endcase
        // break start only while enabled, cts not looked at
        if (c_start_brk && tx_en_q) begin
            bp_d = 1'b1; // see R14
        end
        if (c_stop_brk) begin
            bp_d = 1'b0;
            be_d = (st_q == TX_BRK); // see R15
        end
        // enable only acts from disabled
        if (c_tx_en && !tx_en_q) begin
            ten_d = 1'b1; // see R17
            trdy_d = 1'b1;
            temp_d = 1'b1;
        end
        // disable lets the frame on the line finish
        if (c_tx_dis && tx_en_q) begin
            ten_d = 1'b0; // see R18
            trdy_d = 1'b0;
            temp_d = 1'b0;
        end
        // reset stops the line at once
        if (c_rst_tx) begin
            ten_d = 1'b0; // see R10
            trdy_d = 1'b0;
            temp_d = 1'b0;
            st_d = TX_IDLE;
            txo_d = 1'b1;
            bp_d = 1'b0;
            be_d = 1'b0;
        end
    end

    // transmitter registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= TX_IDLE;
            sh_q <= 8'h00;
            hold_q <= 8'h00;
            bit_q <= 3'h0;
            txo_q <= 1'b1;
            bp_q <= 1'b0;
            be_q <= 1'b0;
            tx_en_q <= 1'b0;
            tx_rdy_q <= 1'b0;
            tx_emp_q <= 1'b0;
        end else begin
            st_q <= st_d;
            sh_q <= sh_d;
            hold_q <= hold_d;
            bit_q <= bit_d;
            txo_q <= txo_d;
            bp_q <= bp_d;
            be_q <= be_d;
            tx_en_q <= ten_d; // see R16
            tx_rdy_q <= trdy_d;
            tx_emp_q <= temp_d;
        end
    end

    // receiver command and fifo accounting
    wire rx_full = (fifo_cnt_q == FIFO_FULL);
    wire push = rx_char_in & rx_act_q;
    wire pop = ap_rd & hit(ap_addr, OFF_RXPOP) & (fifo_cnt_q != 2'h0);
    wire rx_en_d = c_rst_rx | c_rx_dis ? 1'b0 :
                   (c_rx_en & ~multidrop_mode) ? 1'b1 : rx_en_q; // see R20 see R21
    wire [1:0] cnt_d = c_rst_rx ? 2'h0 :
                       (push & ~rx_full & ~pop) ? fifo_cnt_q + 2'h1 :
                       (pop & ~push) ? fifo_cnt_q - 2'h1 : fifo_cnt_q; // see R8
    wire take = push & ~rx_full;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_en_q <= 1'b0;
            rx_act_q <= 1'b0;
            fifo_cnt_q <= 2'h0;
            hunt_q <= 1'b0;
            fifo_rst_q <= 1'b0;
            mptr_q <= 1'b0;
        end else begin
            rx_en_q <= rx_en_d;
            rx_act_q <= rx_en_d | loopback_mode | multidrop_mode; // see R21
            fifo_cnt_q <= cnt_d;
            hunt_q <= c_rx_en & ~multidrop_mode & ~rx_en_q & ~c_rst_rx; // see R20
            fifo_rst_q <= c_rst_rx; // see R8
            mptr_q <= c_mptr; // see R7
        end
    end

    // error flags: a set in the clear cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rb_q <= 1'b0;
            fe_q <= 1'b0;
            pe_q <= 1'b0;
            oe_q <= 1'b0;
            db_q <= 1'b0;
        end else begin
            rb_q <= (take & rx_break_in) | (rb_q & ~c_rst_err); // see R11
            fe_q <= (take & rx_frame_err_in) | (fe_q & ~c_rst_err);
            pe_q <= (take & rx_parity_err_in) | (pe_q & ~c_rst_err);
            oe_q <= (push & rx_full) | (oe_q & ~c_rst_err);
            db_q <= rx_break_change_in | (db_q & ~c_rst_brk); // see R12
        end
    end

    // read data; misc codes 000 and command fields are not readable
    wire [31:0] status_w = {8'h00, csr_q, 4'h0, db_q, (st_q == TX_BRK), rx_act_q,
                            tx_en_q, rb_q, fe_q, pe_q, oe_q, tx_emp_q, tx_rdy_q,
                            rx_full, fifo_cnt_q != 2'h0}; // see R6
    wire [31:0] rmux = hit(ap_addr, OFF_STATUS) ? status_w : 32'h0000_0000;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (ap_rd) begin
            rdata_q <= rmux;
        end
    end

    // outputs straight from flops, hresp tied low
    assign hrdata = rdata_q;
    assign hreadyout = ready_q;
    assign hresp = 1'b0;
    assign serial_tx_out = txo_q;
    assign rx_enable = rx_act_q;
    assign rx_hunt_start = hunt_q;
    assign rx_fifo_reset = fifo_rst_q;
    assign mode_ptr_reset = mptr_q;

    // checks
    property p_rx_nosrc;
        @(posedge hclk) disable iff (!hresetn)
        !ucs_sel_ok(rx_sel_q) && !ucs_sel_ok($past(rx_sel_q)) |-> !rx_bit_tick;
    endproperty
    a_rx_nosrc: assert property (p_rx_nosrc) else $error("rx tick without source"); // see R1
    property p_tx_nosrc;
        @(posedge hclk) disable iff (!hresetn)
        !ucs_sel_ok(tx_sel_q) && st_q == TX_IDLE && !bp_q |=> st_q == TX_IDLE;
    endproperty
    a_tx_nosrc: assert property (p_tx_nosrc) else $error("tx moved without source"); // see R2
    property p_csr;
        @(posedge hclk) disable iff (!hresetn)
        wr_csr |=> rx_sel_q == $past(hwdata[7:4]) && tx_sel_q == $past(hwdata[3:0]);
    endproperty
    a_csr: assert property (p_csr) else $error("clock select not split"); // see R3
    property p_ptr;
        @(posedge hclk) disable iff (!hresetn)
        c_mptr |=> mode_ptr_reset ##1 !mode_ptr_reset;
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer reset not one pulse"); // see R7
    property p_rstrx;
        @(posedge hclk) disable iff (!hresetn)
        c_rst_rx |=> !rx_en_q && fifo_cnt_q == 2'h0 && rx_fifo_reset;
    endproperty
    a_rstrx: assert property (p_rstrx) else $error("receiver reset failed"); // see R8
    property p_rsttx;
        @(posedge hclk) disable iff (!hresetn)
        c_rst_tx |=> !tx_en_q && !tx_rdy_q && !tx_emp_q && serial_tx_out;
    endproperty
    a_rsttx: assert property (p_rsttx) else $error("transmitter reset failed"); // see R10
    property p_rsterr;
        @(posedge hclk) disable iff (!hresetn)
        c_rst_err && !push |=> !rb_q && !fe_q && !pe_q && !oe_q;
    endproperty
    a_rsterr: assert property (p_rsterr) else $error("error flags kept"); // see R11
    property p_brk_en;
        @(posedge hclk) disable iff (!hresetn)
        c_start_brk && !tx_en_q && !bp_q |=> !bp_q;
    endproperty
    a_brk_en: assert property (p_brk_en) else $error("break taken while disabled"); // see R14
    property p_brk_end;
        @(posedge hclk) disable iff (!hresetn)
        st_q == TX_BRK && be_q && tx_tick && !c_rst_tx |=> serial_tx_out;
    endproperty
    a_brk_end: assert property (p_brk_end) else $error("break did not end"); // see R15
    property p_txen;
        @(posedge hclk) disable iff (!hresetn)
        c_tx_en && !tx_en_q && !c_rst_tx |=> tx_en_q && tx_rdy_q && tx_emp_q;
    endproperty
    a_txen: assert property (p_txen) else $error("enable flags wrong"); // see R17
    property p_txdis;
        @(posedge hclk) disable iff (!hresetn)
        c_tx_dis && st_q == TX_DATA && !c_rst_tx |=> !tx_en_q && st_q != TX_IDLE;
    endproperty
    a_txdis: assert property (p_txdis) else $error("disable cut a character"); // see R18
    property p_hunt;
        @(posedge hclk) disable iff (!hresetn)
        c_rx_en && !multidrop_mode && !rx_en_q && !c_rst_rx |=> rx_hunt_start && rx_enable;
    endproperty
    a_hunt: assert property (p_hunt) else $error("receiver enable missed"); // see R20
    c_mixed: cover property (@(posedge hclk) disable iff (!hresetn)
        wr_csr && hwdata[7:4] != hwdata[3:0]);
    c_break: cover property (@(posedge hclk) disable iff (!hresetn)
        st_q == TX_BRK ##[1:400] st_q == TX_START);
    c_full: cover property (@(posedge hclk) disable iff (!hresetn) push && rx_full);
endmodule : ucs_top

/* File: testbench/ucs_line_rx.sv */
// serial line partner: remote receiver sampling the transmit line
`timescale 1ns/1ps
module ucs_line_rx #(
    parameter int BIT_CYC = 512
) (
    input wire logic hclk,
    input wire logic line,
    output logic [8:0] frame,
    output int nfr
);
    // hunt a start edge, sample mid-bit, stop bit lands in frame[8]
    initial begin
        frame = 9'h000;
        nfr = 0;
        forever begin
            @(negedge line);
            repeat (BIT_CYC / 2) @(posedge hclk);
            for (int i = 0; i < 9; i++) begin
                repeat (BIT_CYC) @(posedge hclk);
                frame[i] = line; // lsb first
            end
            nfr++;
        end
    end
endmodule : ucs_line_rx

/* File: testbench/ucs_top_bench.sv */
// bench: ahb-lite register access, command decode and serial line checks
`timescale 1ns/1ps
module ucs_top_bench;
    import ucs_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, st;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic ext_timer_clock_in, clear_to_send_in_n, multidrop_mode, loopback_mode;
    logic rx_char_in, rx_break_in, rx_frame_err_in, rx_parity_err_in, rx_break_change_in;
    logic serial_tx_out, rx_enable, rx_hunt_start, rx_fifo_reset, mode_ptr_reset, rx_bit_tick;
    logic [8:0] frame;
    int nfr, failures, cmp_count, k, c;
    assign hready = hreadyout;
    ucs_top u_ucs_top (.*);
    ucs_line_rx u_ucs_line_rx (.hclk, .line(serial_tx_out), .frame, .nfr);
    // 100 mhz clock
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // external timer clock, one rise every 6 cycles
    always begin
        repeat (3) @(posedge hclk);
        ext_timer_clock_in <= ~ext_timer_clock_in;
    end
    task report_and_stop;
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // one clock of a bounded wait
    task tick(input int lim);
        @(posedge hclk);
        k++;
        if (k > lim) begin
            failures++;
            report_and_stop;
        end
    endtask : tick
    // single ahb transfer, read data left in st
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        k = 0;
        tick(50);
        while (hreadyout !== 1'b1) tick(50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        k = 0;
        tick(50);
        while (hreadyout !== 1'b1) tick(50);
        st = hrdata;
    endtask : xfer
    task cmd(input logic [7:0] v);
        xfer(OFF_CMD, 1'b1, {24'h000000, v});
    endtask : cmd
    task stat(input string nm, input logic [31:0] m, input logic [31:0] e);
        xfer(OFF_STATUS, 1'b0, 32'h0);
        chk(nm, st & m, e);
    endtask : stat
    // bit time of the receiver for one clock select value
    task gap(input logic [7:0] cs, input int e);
        xfer(OFF_CLKSEL, 1'b1, {24'h000000, cs});
        for (int j = 0; j < 3; j++) begin
            k = 0;
            tick(5000);
            while (rx_bit_tick !== 1'b1) tick(5000);
        end
        chk("rx bit time", k, e);
        stat("clksel", 32'h00FF0000, {8'h00, cs, 16'h0000});
    endtask : gap
    task rxin(input logic b, input logic f, input logic p);
        @(posedge hclk);
        rx_char_in <= 1'b1;
        rx_break_in <= b;
        rx_frame_err_in <= f;
        rx_parity_err_in <= p;
        @(posedge hclk);
        rx_char_in <= 1'b0;
    endtask : rxin
    task wline(input logic v, input int lim);
        k = 0;
        while (serial_tx_out !== v) tick(lim);
    endtask : wline
    task wfr(input int n);
        k = 0;
        while (nfr < n) tick(12000);
    endtask : wfr
    initial begin
        {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
        hsize = 3'h2;
        {ext_timer_clock_in, clear_to_send_in_n, multidrop_mode, loopback_mode} = '0;
        {rx_char_in, rx_break_in, rx_frame_err_in, rx_parity_err_in} = '0;
        rx_break_change_in = 1'b0;
        failures = 0;
        cmp_count = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        stat("status reset", 32'hFFFFFFFF, 32'h0);
        xfer(OFF_CLKSEL, 1'b0, 32'h0);
        chk("clksel read", st, 32'h0);
        xfer(8'h20, 1'b0, 32'h0);
        chk("unmapped", st, 32'h0);
        // receiver: enable, clock sources, flags
        cmd(8'h01);
        #1 chk("hunt", rx_hunt_start, 1'b1);
        gap(8'hED, 1536);
        gap(8'hFD, 96);
        gap(8'hDD, 512);
        rxin(1'b1, 1'b1, 1'b1);
        stat("rx errors", 32'hFF, 32'hE1);
        cmd(8'h40);
        stat("errors cleared", 32'hFF, 32'h01);
        rxin(1'b0, 1'b0, 1'b0);
        rxin(1'b0, 1'b0, 1'b0);
        stat("fifo full", 32'h3, 32'h3);
        cmd(8'h20);
        #1 chk("fifo reset", rx_fifo_reset, 1'b1);
        stat("rx reset", 32'h203, 32'h0);
        @(posedge hclk);
        rx_break_change_in <= 1'b1;
        @(posedge hclk);
        rx_break_change_in <= 1'b0;
        stat("delta break", 32'h800, 32'h800);
        cmd(8'h50);
        stat("delta cleared", 32'h800, 32'h0);
        cmd(8'h10);
        #1 chk("ptr pulse", mode_ptr_reset, 1'b1);
        @(posedge hclk);
        #1 chk("ptr pulse end", mode_ptr_reset, 1'b0);
        multidrop_mode <= 1'b1;
        cmd(8'h01);
        #1 chk("no hunt multidrop", rx_hunt_start, 1'b0);
        multidrop_mode <= 1'b0;
        cmd(8'h01);
        loopback_mode <= 1'b1;
        cmd(8'h02);
        repeat (2) @(posedge hclk);
        chk("rx loopback", rx_enable, 1'b1);
        loopback_mode <= 1'b0;
        repeat (2) @(posedge hclk);
        chk("rx disabled", rx_enable, 1'b0);
        // transmitter; tx code 11 is never written
        cmd(8'h04);
        stat("tx enable", 32'h10C, 32'h10C);
        cmd(8'h00);
        stat("no action", 32'h10C, 32'h10C);
        c = nfr;
        xfer(OFF_TXDATA, 1'b1, 32'h5A);
        wfr(c + 1);
        chk("frame", frame, 9'h15A);
        clear_to_send_in_n <= 1'b1;
        cmd(8'h60);
        wline(1'b0, 1100);
        stat("break on", 32'h400, 32'h400);
        xfer(OFF_TXDATA, 1'b1, 32'hA5);
        repeat (5200) @(posedge hclk);
        cmd(8'h70);
        wline(1'b1, 1100);
        clear_to_send_in_n <= 1'b0;
        c = nfr;
        wfr(c + 1);
        chk("held char", frame, 9'h1A5);
        c = nfr;
        xfer(OFF_TXDATA, 1'b1, 32'h3C);
        wline(1'b0, 1200);
        cmd(8'h08);
        stat("tx disable", 32'hC, 32'h0);
        wfr(c + 1);
        chk("last frame", frame, 9'h13C);
        cmd(8'h04);
        cmd(8'h30);
        stat("tx reset", 32'h10C, 32'h0);
        report_and_stop;
    end
endmodule : ucs_top_bench
